// ### ssic_pkg.sv
// shared constants, types and functions for the sram input control block
package ssic_pkg;

  localparam int unsigned SSIC_ADDR_W     = 19;
  localparam int unsigned SSIC_LANES      = 4;
  localparam int unsigned SSIC_LANE_W     = 8;
  localparam int unsigned SSIC_BURST_W    = 2;
  localparam int unsigned SSIC_BURST_LSB  = 0;

  localparam logic [1:0]  SSIC_BURST_RST  = 2'h0;
  localparam logic [1:0]  SSIC_BURST_ONE  = 2'h1;
  localparam logic        SSIC_ORDER_RST  = 1'h1;

  // order strap: low selects linear, high or open selects interleaved
  localparam logic        SSIC_ORDER_LIN  = 1'h0;

  // access kind held from one recognised edge to the next
  typedef enum logic [1:0] {
    SSIC_DESEL = 2'h0,
    SSIC_READ  = 2'h1,
    SSIC_WRITE = 2'h3
  } ssic_access_type;

  // low address bits of a burst; both orders stay within the group of four
  function automatic logic [1:0] ssic_burst_low(
    input logic [1:0] start,
    input logic [1:0] count,
    input logic       order
  );
    logic [1:0] sum;
    sum = start + count;
    ssic_burst_low = (order == SSIC_ORDER_LIN) ? sum : (start ^ count);
  endfunction

endpackage

// ### ssic_burst_if.sv
// carrier between the control core and the burst counter
`timescale 1ns/1ps
interface ssic_burst_if;
  logic       load;
  logic       step;
  logic       hold;
  logic [1:0] start;
  logic       order;
  logic [1:0] low_next;

  modport ctrl (
    output load,
    output step,
    output hold,
    output start,
    output order,
    input  low_next
  );

  modport ctr (
    input  load,
    input  step,
    input  hold,
    input  start,
    input  order,
    output low_next
  );
endinterface

// ### ssic_burst.sv
// two-bit burst counter with linear or interleaved order
`timescale 1ns/1ps
module ssic_burst
  import ssic_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  ssic_burst_if.ctr bif
);

  logic [1:0] start;
  logic [1:0] count;
  logic [1:0] next_count;
  logic [1:0] count_plus;

  assign count_plus = count + SSIC_BURST_ONE;
  // value after the coming step, so the core can address it at this edge
  assign bif.low_next = ssic_burst_low(start, count_plus, bif.order);

  always_comb begin
    next_count = count;
    if (bif.hold) begin
      next_count = count;
    end else if (bif.load) begin
      next_count = SSIC_BURST_RST;
    end else if (bif.step) begin
      next_count = count_plus;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start <= SSIC_BURST_RST;
      count <= SSIC_BURST_RST;
    end else begin
      count <= next_count;
      if (!bif.hold && bif.load) begin
        start <= bif.start;
      end
    end
  end

endmodule // ssic_burst

// ### ssic_top.sv
// input capture, burst, byte-write and output-drive control of the sram
`timescale 1ns/1ps
module ssic_top
  import ssic_pkg::*;
#(
  parameter int unsigned ADDR_W = SSIC_ADDR_W,
  parameter int unsigned LANES  = SSIC_LANES,
  parameter int unsigned LANE_W = SSIC_LANE_W
) (
  input  wire logic                     CLK,
  input  wire logic                     RST_B,
  input  wire logic [ADDR_W-1:0]        ADDR,
  input  wire logic [LANES-1:0]         BYTE_LANE_WRITE_N,
  input  wire logic                     WRITE_STROBE_N,
  input  wire logic                     ADVANCE_LOAD_SEL,
  input  wire logic                     CLOCK_GATE_N,
  input  wire logic                     CHIP_SELECT_FIRST_N,
  input  wire logic                     CHIP_SELECT_SECOND,
  input  wire logic                     CHIP_SELECT_THIRD_N,
  input  wire logic                     OUTPUT_DRIVE_N,
  input  wire logic                     BURST_ORDER_STRAP,
  input  wire logic [LANES*LANE_W-1:0]  DATA_IN,
  input  wire logic [LANES-1:0]         PARITY_IN,
  input  wire logic [LANES*LANE_W-1:0]  MEM_RDATA,
  input  wire logic [LANES-1:0]         MEM_RPARITY,
  output logic      [ADDR_W-1:0]        MEM_ADDR,
  output logic                          MEM_READ,
  output logic      [ADDR_W-1:0]        MEM_WADDR,
  output logic      [LANES-1:0]         MEM_WRITE_LANE,
  output logic      [LANES*LANE_W-1:0]  MEM_WDATA,
  output logic      [LANES-1:0]         MEM_WPARITY,
  output logic      [LANES*LANE_W-1:0]  DATA_OUT,
  output logic      [LANES-1:0]         PARITY_OUT,
  output logic                          DATA_OE,
  output logic                          PARITY_OE,
  output logic                          SELECTED
);

  ssic_burst_if bif ();

  ssic_burst u_burst (
    .clk   (CLK),
    .rst_b (RST_B),
    .bif   (bif)
  );

  ssic_access_type access;
  ssic_access_type next_access;
  logic                      order;
  logic                      drive_slot;
  logic [ADDR_W-1:0]         wr_addr;
  logic [LANES-1:0]          wr_lanes;
  logic                      wr_pend;

  wire logic                 edge_ok;
  wire logic                 chip_sel;
  wire logic                 load_req;
  wire logic                 adv_req;
  wire logic [ADDR_W-1:0]    adv_addr;
  wire logic [ADDR_W-1:0]    next_addr;
  wire logic [LANES-1:0]     lane_sel;

  assign edge_ok  = !CLOCK_GATE_N;
  assign chip_sel = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND
                    && !CHIP_SELECT_THIRD_N;
  assign load_req = !ADVANCE_LOAD_SEL;
  assign adv_req  = ADVANCE_LOAD_SEL && access != SSIC_DESEL;
  // upper bits kept, only the low pair walks
  assign adv_addr = {MEM_ADDR[ADDR_W-1:SSIC_BURST_W], bif.low_next};
  assign next_addr = load_req ? ADDR : adv_addr;
  assign lane_sel  = ~BYTE_LANE_WRITE_N;

  assign bif.hold  = !edge_ok;
  assign bif.load  = load_req;
  assign bif.step  = adv_req;
  assign bif.start = ADDR[SSIC_BURST_LSB +: SSIC_BURST_W];
  assign bif.order = order;

  // an advance while deselected stays deselected; controller loads anew
  always_comb begin
    next_access = access;
    if (load_req) begin
      if (!chip_sel) begin
        next_access = SSIC_DESEL;
      end else if (!WRITE_STROBE_N) begin
        next_access = SSIC_WRITE;
      end else begin
        next_access = SSIC_READ;
      end
    end else begin
      case (access)
        SSIC_DESEL: next_access = SSIC_DESEL;
        SSIC_READ:  next_access = SSIC_READ;
        SSIC_WRITE: next_access = SSIC_WRITE;
        default:    next_access = SSIC_DESEL;
      endcase
    end
  end

  // strap sampled every clock, never under reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      order <= SSIC_ORDER_RST;
    end else begin
      order <= BURST_ORDER_STRAP;
    end
  end

  // next values of the registered outputs, decoded once
  wire logic                 next_read;
  wire logic                 next_selected;
  wire logic                 next_write;
  wire logic [LANES-1:0]     next_write_lane;

  assign next_read       = (next_access == SSIC_READ);
  assign next_selected   = (next_access != SSIC_DESEL);
  assign next_write      = (next_access == SSIC_WRITE);
  assign next_write_lane = wr_pend ? wr_lanes : '0;

  // access kind; gate high holds it, and all other state except the write lanes (cleared) and the strap
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      access <= SSIC_DESEL;
    end else if (edge_ok) begin
      access <= next_access;
    end
  end

  // address walks only in its low pair during a burst
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_ADDR <= '0;
    end else if (edge_ok) begin
      MEM_ADDR <= next_addr;
    end
  end

  // flags follow the access kind they describe
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_READ <= 1'b0;
      SELECTED <= 1'b0;
    end else if (edge_ok) begin
      MEM_READ <= next_read;
      SELECTED <= next_selected;
    end
  end

  // write data arrives one recognised edge after its address
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend  <= 1'b0;
      wr_addr  <= '0;
      wr_lanes <= '0;
    end else if (edge_ok) begin
      wr_pend  <= next_write;
      wr_addr  <= next_addr;
      wr_lanes <= lane_sel;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_WADDR   <= '0;
      MEM_WDATA   <= '0;
      MEM_WPARITY <= '0;
    end else if (edge_ok) begin
      MEM_WADDR   <= wr_addr;
      MEM_WDATA   <= DATA_IN;
      MEM_WPARITY <= PARITY_IN;
    end
  end

  // a stretched cycle must not write twice
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_WRITE_LANE <= '0;
    end else if (edge_ok) begin
      MEM_WRITE_LANE <= next_write_lane;
    end else begin
      MEM_WRITE_LANE <= '0;
    end
  end

  // drive only in the data slot of a selected read
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      drive_slot <= 1'b0;
    end else if (edge_ok) begin
      drive_slot <= MEM_READ;
    end
  end

  // output data held across a stretched cycle as well
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      DATA_OUT   <= '0;
      PARITY_OUT <= '0;
    end else if (edge_ok) begin
      DATA_OUT   <= MEM_RDATA;
      PARITY_OUT <= MEM_RPARITY;
    end
  end

  // the drive enable pin is asynchronous, so it gates the slot directly
  assign DATA_OE   = drive_slot && !OUTPUT_DRIVE_N;
  assign PARITY_OE = drive_slot && !OUTPUT_DRIVE_N;

endmodule // ssic_top

// ### ssic_top_assertions.sv
// port assertions for the sram input control
`timescale 1ns/1ps
module ssic_top_assertions
  import ssic_pkg::*;
#(
  parameter int unsigned ADDR_W = SSIC_ADDR_W
) (
  input wire logic              CLK,
  input wire logic              RST_B,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [3:0]        BYTE_LANE_WRITE_N,
  input wire logic              WRITE_STROBE_N,
  input wire logic              ADVANCE_LOAD_SEL,
  input wire logic              CLOCK_GATE_N,
  input wire logic              CHIP_SELECT_FIRST_N,
  input wire logic              CHIP_SELECT_SECOND,
  input wire logic              CHIP_SELECT_THIRD_N,
  input wire logic              OUTPUT_DRIVE_N,
  input wire logic              BURST_ORDER_STRAP,
  input wire logic [31:0]       MEM_RDATA,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic [ADDR_W-1:0] MEM_WADDR,
  input wire logic [3:0]        MEM_WRITE_LANE,
  input wire logic [31:0]       DATA_OUT,
  input wire logic              DATA_OE,
  input wire logic              PARITY_OE,
  input wire logic              SELECTED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  wire logic sel_in = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND
                      && !CHIP_SELECT_THIRD_N;
  wire logic go = !CLOCK_GATE_N;
  wire logic ld = go && !ADVANCE_LOAD_SEL;
  wire logic adv = go && ADVANCE_LOAD_SEL && SELECTED;
  wire logic wr = ld && sel_in && !WRITE_STROBE_N;
  gate_hold_a: assert property (
    CLOCK_GATE_N |=> $stable(MEM_ADDR) && $stable(SELECTED)
    && MEM_WRITE_LANE == 4'h0) else $error("state moved on gated edge");
  load_addr_a: assert property (
    ld && sel_in |=> MEM_ADDR == $past(ADDR)) else $error("address not loaded");
  upper_keep_a: assert property (
    adv |=> MEM_ADDR[ADDR_W-1:2] == $past(MEM_ADDR[ADDR_W-1:2]))
    else $error("burst touched upper address");
  lin_step_a: assert property (
    adv && !BURST_ORDER_STRAP && !$past(BURST_ORDER_STRAP)
    |=> MEM_ADDR[1:0] == $past(MEM_ADDR[1:0]) + 2'h1)
    else $error("linear burst step wrong");
  oe_mask_a: assert property (
    OUTPUT_DRIVE_N |-> !DATA_OE && !PARITY_OE) else $error("drive not masked");
  read_data_a: assert property (
    ld && sel_in && WRITE_STROBE_N ##1 go |=> OUTPUT_DRIVE_N
    || (DATA_OE && PARITY_OE && DATA_OUT == $past(MEM_RDATA)))
    else $error("read data slot wrong");
  write_mask_a: assert property (
    (wr || (ld && !sel_in)) ##1 go |=> !DATA_OE && !PARITY_OE)
    else $error("drove in write or deselect slot");
  write_lane_a: assert property (
    wr ##1 go |=> MEM_WRITE_LANE == ~$past(BYTE_LANE_WRITE_N, 2)
    && MEM_WADDR == $past(ADDR, 2)) else $error("write lanes wrong");
endmodule // ssic_top_assertions

bind ssic_top ssic_top_assertions #(.ADDR_W(ADDR_W)) ssic_top_assertions_i (.*);

// ### ssic_array_model.sv
// storage array behind the sram input control
`timescale 1ns/1ps
module ssic_array_model (
  input  wire logic        CLK,
  input  wire logic [18:0] MEM_ADDR,
  input  wire logic [18:0] MEM_WADDR,
  input  wire logic [3:0]  MEM_WRITE_LANE,
  input  wire logic [31:0] MEM_WDATA,
  input  wire logic [3:0]  MEM_WPARITY,
  output logic      [31:0] MEM_RDATA,
  output logic      [3:0]  MEM_RPARITY
);
  // only sixteen words kept, enough for the bench
  logic [35:0] mem [16];
  assign {MEM_RPARITY, MEM_RDATA} = mem[MEM_ADDR[3:0]];
  // known contents, so bursts over unwritten words stay comparable
  initial begin
    for (int j = 0; j < 16; j++) begin
      mem[j] = '0;
    end
  end
  always @(posedge CLK) begin
    for (int i = 0; i < 4; i++) begin
      if (MEM_WRITE_LANE[i]) begin
        mem[MEM_WADDR[3:0]][8*i +: 8] <= MEM_WDATA[8*i +: 8];
        mem[MEM_WADDR[3:0]][32+i] <= MEM_WPARITY[i];
      end
    end
  end
endmodule // ssic_array_model

// ### test_sync_sram_input_control.sv
// self-checking bench for the sram input control
`timescale 1ns/1ps
module test_sync_sram_input_control;
  logic CLK = 1'b0, RST_B = 1'b0, WRITE_STROBE_N = 1'b1, ADVANCE_LOAD_SEL = 1'b0;
  logic CLOCK_GATE_N = 1'b0, OUTPUT_DRIVE_N = 1'b0, BURST_ORDER_STRAP = 1'b0;
  logic CHIP_SELECT_FIRST_N = 1'b1, CHIP_SELECT_SECOND = 1'b1;
  logic CHIP_SELECT_THIRD_N = 1'b0;
  logic [18:0] ADDR = '0;
  logic [3:0]  BYTE_LANE_WRITE_N = 4'hF, PARITY_IN = 4'h0;
  logic [31:0] DATA_IN = '0;
  wire  [18:0] MEM_ADDR, MEM_WADDR;
  wire  [31:0] MEM_RDATA, MEM_WDATA, DATA_OUT;
  wire  [3:0]  MEM_RPARITY, MEM_WRITE_LANE, MEM_WPARITY, PARITY_OUT;
  wire         MEM_READ, DATA_OE, PARITY_OE, SELECTED;
  int err_total = 0, checks_done = 0, cycles = 0;
  ssic_top ssic_top_i (.*);
  ssic_array_model ssic_array_model_i (.*);
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one cycle of controller pins; cs is first, second, third select
  task automatic drv(input logic [2:0] cs, input logic adv, wen,
                     input logic [3:0] bw, input logic [18:0] a,
                     input logic [35:0] d);
    @(posedge CLK);
    #1;
    {CHIP_SELECT_FIRST_N, CHIP_SELECT_SECOND, CHIP_SELECT_THIRD_N} = cs;
    ADVANCE_LOAD_SEL = adv;
    WRITE_STROBE_N = wen;
    BYTE_LANE_WRITE_N = bw;
    ADDR = a;
    {PARITY_IN, DATA_IN} = d;
  endtask
  task automatic t_rw();
    drv(3'b010, 1'b0, 1'b0, 4'h0, 19'h0_0005, '0);
    drv(3'b010, 1'b0, 1'b0, 4'hA, 19'h0_0005, 36'hF_AAAA_AAAA);
    drv(3'b110, 1'b0, 1'b1, 4'hF, '0, 36'h0_5555_5555);
    chk("lanes", MEM_WRITE_LANE, 4'hF);
    chk("oe write", DATA_OE, 1'b0);
    drv(3'b010, 1'b0, 1'b1, 4'hF, 19'h0_0005, '0);
    chk("lanes", MEM_WRITE_LANE, 4'h5);
    drv(3'b110, 1'b0, 1'b1, 4'hF, '0, '0);
    chk("read", {MEM_READ, SELECTED, MEM_ADDR}, 21'h18_0005);
    chk("oe emerge", DATA_OE, 1'b0);
    drv(3'b110, 1'b0, 1'b1, 4'hF, '0, '0);
    chk("data", {PARITY_OUT, DATA_OUT}, 36'hA_AA55_AA55);
    chk("oe read", {DATA_OE, PARITY_OE}, 2'h3);
    drv(3'b110, 1'b0, 1'b1, 4'hF, '0, '0);
    chk("oe desel", DATA_OE, 1'b0);
  endtask
  task automatic t_burst(input logic ord, input logic [9:0] seq);
    BURST_ORDER_STRAP = ord;
    drv(3'b010, 1'b0, 1'b1, 4'hF, 19'h5_5551, '0);
    for (int k = 0; k < 5; k++) begin
      drv(3'b010, 1'b1, 1'b1, 4'hF, '0, '0);
      chk("burst", MEM_ADDR, {17'h1_5554, seq[2*k +: 2]});
    end
    drv(3'b110, 1'b0, 1'b1, 4'hF, '0, '0);
  endtask
  task automatic t_gate();
    drv(3'b010, 1'b0, 1'b1, 4'hF, 19'h0_0005, '0);
    drv(3'b110, 1'b0, 1'b0, 4'h0, 19'h7_0000, '0);
    CLOCK_GATE_N = 1'b1;
    repeat (3) drv(3'b110, 1'b0, 1'b0, 4'h0, 19'h7_0000, '0);
    chk("held", {SELECTED, MEM_ADDR}, 20'h8_0005);
    chk("no write", MEM_WRITE_LANE, 4'h0);
    CLOCK_GATE_N = 1'b0;
    drv(3'b110, 1'b0, 1'b1, 4'hF, '0, '0);
    chk("gated data", {PARITY_OUT, DATA_OUT}, 36'hA_AA55_AA55);
    chk("oe on", DATA_OE, 1'b1);
    OUTPUT_DRIVE_N = 1'b1;
    #1;
    chk("oe off", DATA_OE, 1'b0);
    @(posedge CLK);
    #1;
    OUTPUT_DRIVE_N = 1'b0;
  endtask
  task automatic t_sel();
    for (int c = 0; c < 8; c++) begin
      drv(3'(c), 1'b0, 1'b1, 4'hF, 19'h0_0005, '0);
      drv(3'b110, 1'b0, 1'b1, 4'hF, '0, '0);
      chk("selected", SELECTED, 1'(c == 2));
    end
  endtask
  initial begin
    repeat (20) @(posedge CLK);
    #1;
    RST_B = 1'b1;
    t_rw();
    t_burst(1'b0, 10'h139);
    t_burst(1'b1, 10'h1B1);
    t_gate();
    t_sel();
    tally_and_finish();
  end
endmodule // test_sync_sram_input_control
